/* rtl/rtca_pkg.sv */
// Constants, register map and timing for the time, calendar and alarm core
package rtca_pkg;

    localparam int unsigned SYS_CLK_HZ     = 40_000_000;
    localparam int unsigned TB_FREQ_HZ     = 32_768;
    localparam int unsigned LEAD_TIME_US   = 244;
    localparam int unsigned UPDATE_TIME_US = 1948;
    // Time-base ticks, least times rounded up
    localparam int unsigned LEAD_TICKS     = (LEAD_TIME_US * TB_FREQ_HZ + 999_999) / 1_000_000;
    localparam int unsigned UPDATE_TICKS   = (UPDATE_TIME_US * TB_FREQ_HZ + 999_999) / 1_000_000;
    localparam int unsigned DIV_WIDTH      = 15;

    localparam logic [6:0] ADDR_SEC        = 7'h00;
    localparam logic [6:0] ADDR_SEC_ALM    = 7'h01;
    localparam logic [6:0] ADDR_MIN        = 7'h02;
    localparam logic [6:0] ADDR_MIN_ALM    = 7'h03;
    localparam logic [6:0] ADDR_HOUR       = 7'h04;
    localparam logic [6:0] ADDR_HOUR_ALM   = 7'h05;
    localparam logic [6:0] ADDR_WDAY       = 7'h06;
    localparam logic [6:0] ADDR_MDAY       = 7'h07;
    localparam logic [6:0] ADDR_MONTH      = 7'h08;
    localparam logic [6:0] ADDR_YEAR       = 7'h09;
    localparam logic [6:0] ADDR_DIV_RATE   = 7'h0A;
    localparam logic [6:0] ADDR_MODE       = 7'h0B;
    localparam logic [6:0] ADDR_IRQ_FLAGS  = 7'h0C;
    localparam logic [6:0] ADDR_MDAY_ALM   = 7'h0D;
    localparam logic [6:0] ADDR_CENTURY    = 7'h32;
    localparam logic [6:0] ADDR_SHARED     = 7'h7F;

    // Mode register bit positions
    localparam int unsigned MODE_HALT_BIT  = 7;
    localparam int unsigned MODE_PIE_BIT   = 6;
    localparam int unsigned MODE_AIE_BIT   = 5;
    localparam int unsigned MODE_UIE_BIT   = 4;
    localparam int unsigned MODE_BIN_BIT   = 2;
    localparam int unsigned MODE_H24_BIT   = 1;
    localparam logic [7:0]  MODE_WR_MASK   = 8'hF6;

    localparam logic [7:0] RST_TIME        = 8'h00;
    localparam logic [7:0] RST_DAY         = 8'h01;
    localparam logic [6:0] RST_DIV_RATE    = 7'h00;
    localparam logic [7:0] RST_MODE        = 8'h00;
    localparam logic [7:0] UNDEF_DATA      = 8'hFF;
    localparam logic [1:0] ALM_DONT_CARE   = 2'b11;

    typedef enum logic [1:0]
    {
        UPD_IDLE,
        UPD_PEND,
        UPD_BUSY
    } rtca_upd_e;

endpackage

/* rtl/rtca_core.sv */
// Time, calendar and alarm counters with update sequencing and bank register access
`timescale 1ns/1ps
module rtca_core
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_b,
    input  wire logic       i_tb_tick,
    input  wire logic [7:0] i_addr,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_rd_en,
    input  wire logic [7:0] i_irq_flags,
    input  wire logic [6:0] i_shared_status,
    output logic      [7:0] o_rd_data,
    output logic            o_update_pending,
    output logic            o_update_done,
    output logic            o_alarm_match,
    output logic      [3:0] o_rate_select,
    output logic      [2:0] o_irq_enables,
    output logic            o_shared_ctrl0
);
    import rtca_pkg::*;

    localparam logic [DIV_WIDTH-1:0] DIV_LAST  = {DIV_WIDTH{1'b1}};
    localparam logic [DIV_WIDTH-1:0] DIV_HALF  = {1'b1, {(DIV_WIDTH-1){1'b0}}};
    localparam logic [DIV_WIDTH-1:0] DIV_PEND  = DIV_WIDTH'(TB_FREQ_HZ - LEAD_TICKS);
    localparam logic [6:0]           BUSY_LAST = 7'(UPDATE_TICKS - 1);

    logic [7:0]           sec_ff, min_ff, hour_ff, wday_ff, mday_ff, month_ff, year_ff, cent_ff;
    logic [7:0]           sec_alm_ff, min_alm_ff, hour_alm_ff;
    logic [5:0]           mday_alm_ff;
    logic                 valid_ram_ff;
    logic [6:0]           div_rate_ff;
    logic [7:0]           mode_ff;
    logic                 shared0_ff;
    logic [7:0]           gp_ram [0:255];
    logic [DIV_WIDTH-1:0] div_cnt_ff;
    logic [6:0]           busy_cnt_ff;
    rtca_upd_e            upd_state_ff;
    logic [7:0]           rd_data_ff;
    logic                 alarm_ff;
    logic                 done_ff, pend_flag_ff;

    logic [7:0]           nxt_sec, nxt_min, nxt_hour, nxt_wday, nxt_mday, nxt_month, nxt_year, nxt_cent;
    logic                 bin_mode, h24_mode, halt, div_reset, div_stop;
    logic                 upd_go, blocked, wr_acc, rd_acc;
    logic [6:0]           idx;

    // Time, calendar and alarm bytes, except the day alarm
    function automatic logic is_timed(input logic [7:0] a);
        return (a[7] == 1'b0) && ((a[6:0] <= ADDR_YEAR) || (a[6:0] == ADDR_CENTURY));
    endfunction

    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
        return bin ? v : 8'(({4'h0, v[7:4]} * 8'd10) + {4'h0, v[3:0]});
    endfunction

    function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
        logic [7:0] tens;
        logic [7:0] ones;
        tens = v / 8'd10;
        ones = v % 8'd10;
        return bin ? v : {tens[3:0], ones[3:0]};
    endfunction

    // Returns carry and next value, wrapping from hi back to lo
    function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic bin);
        logic [7:0] b;
        b = to_bin(v, bin);
        if (b >= hi)
            return {1'b1, from_bin(lo, bin)};
        else
            return {1'b0, from_bin(8'(b + 8'd1), bin)};
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y,
                                              input logic [7:0] c);
        logic leap;
        leap = (y[1:0] == 2'b00) && ((y != 8'd0) || (c[1:0] == 2'b00));
        case (m)
            8'd2:                     month_days = leap ? 8'd29 : 8'd28;
            8'd4, 8'd6, 8'd9, 8'd11:  month_days = 8'd30;
            default:                  month_days = 8'd31;
        endcase
    endfunction

    function automatic logic alm_hit(input logic [7:0] alm, input logic [7:0] cnt);
        return (alm[7:6] == ALM_DONT_CARE) || (alm == cnt);
    endfunction

    assign bin_mode  = mode_ff[MODE_BIN_BIT];
    assign h24_mode  = mode_ff[MODE_H24_BIT];
    assign halt      = mode_ff[MODE_HALT_BIT];
    assign div_reset = (div_rate_ff[6:4] == 3'b001) || (div_rate_ff[6:5] == 2'b11);
    assign div_stop  = (div_rate_ff[6:4] == 3'b011);
    assign idx       = i_addr[6:0];
    assign upd_go    = (upd_state_ff == UPD_PEND) && i_tb_tick && (div_cnt_ff == DIV_LAST) && !halt;
    assign blocked   = (upd_state_ff == UPD_BUSY) || upd_go;
    assign wr_acc    = i_wr_en && !(blocked && is_timed(i_addr));
    assign rd_acc    = i_rd_en;

    // Divider chain on the time base
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            div_cnt_ff <= DIV_HALF;
        else if (div_reset)
            div_cnt_ff <= DIV_HALF;
        else if (i_tb_tick && !div_stop)
            div_cnt_ff <= div_cnt_ff + 1'b1;
    end

    // Update sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            upd_state_ff <= UPD_IDLE;
            busy_cnt_ff  <= 7'h00;
        end
        else if (halt || div_reset || div_stop)
        begin
            upd_state_ff <= UPD_IDLE;
            busy_cnt_ff  <= 7'h00;
        end
        else
        begin
            case (upd_state_ff)
                UPD_IDLE:
                begin
                    if (i_tb_tick && (div_cnt_ff == DIV_PEND - 1'b1))
                        upd_state_ff <= UPD_PEND;
                end
                UPD_PEND:
                begin
                    if (upd_go)
                    begin
                        upd_state_ff <= UPD_BUSY;
                        busy_cnt_ff  <= 7'h00;
                    end
                end
                UPD_BUSY:
                begin
                    if (i_tb_tick)
                    begin
                        if (busy_cnt_ff == BUSY_LAST)
                            upd_state_ff <= UPD_IDLE;
                        else
                            busy_cnt_ff <= busy_cnt_ff + 1'b1;
                    end
                end
                default:
                    upd_state_ff <= UPD_IDLE;
            endcase
        end
    end

    // Next time and calendar values for one second step
    always_comb
    begin
        logic [8:0] r;
        logic [7:0] h;
        logic [7:0] hb;
        logic       carry;
        logic [7:0] dim;
        r         = 9'h000;
        h         = 8'h00;
        hb        = 8'h00;
        carry     = 1'b0;
        dim       = month_days(to_bin(month_ff, bin_mode), to_bin(year_ff, bin_mode), to_bin(cent_ff, bin_mode));
        nxt_sec   = sec_ff;
        nxt_min   = min_ff;
        nxt_hour  = hour_ff;
        nxt_wday  = wday_ff;
        nxt_mday  = mday_ff;
        nxt_month = month_ff;
        nxt_year  = year_ff;
        nxt_cent  = cent_ff;
        r         = step(sec_ff, 8'd0, 8'd59, bin_mode);
        nxt_sec   = r[7:0];
        if (r[8])
        begin
            r       = step(min_ff, 8'd0, 8'd59, bin_mode);
            nxt_min = r[7:0];
            if (r[8])
            begin
                if (h24_mode)
                begin
                    r        = step(hour_ff, 8'd0, 8'd23, bin_mode);
                    nxt_hour = r[7:0];
                    carry    = r[8];
                end
                else
                begin
                    hb = to_bin({1'b0, hour_ff[6:0]}, bin_mode);
                    h  = (hb >= 8'd12) ? 8'd1 : 8'(hb + 8'd1);
                    if (h == 8'd12)
                    begin
                        nxt_hour = {~hour_ff[7], 7'(from_bin(h, bin_mode))};
                        carry    = hour_ff[7];
                    end
                    else
                        nxt_hour = {hour_ff[7], 7'(from_bin(h, bin_mode))};
                end
                if (carry)
                begin
                    r        = step(wday_ff, 8'd1, 8'd7, bin_mode);
                    nxt_wday = r[7:0];
                    r        = step(mday_ff, 8'd1, dim, bin_mode);
                    nxt_mday = r[7:0];
                    if (r[8])
                    begin
                        r         = step(month_ff, 8'd1, 8'd12, bin_mode);
                        nxt_month = r[7:0];
                        if (r[8])
                        begin
                            r        = step(year_ff, 8'd0, 8'd99, bin_mode);
                            nxt_year = r[7:0];
                            if (r[8])
                            begin
                                r        = step(cent_ff, 8'd0, 8'd99, bin_mode);
                                nxt_cent = r[7:0];
                            end
                        end
                    end
                end
            end
        end
    end

    // Time and calendar counters: host writes or update step
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sec_ff   <= RST_TIME;
            min_ff   <= RST_TIME;
            hour_ff  <= RST_TIME;
            wday_ff  <= RST_DAY;
            mday_ff  <= RST_DAY;
            month_ff <= RST_DAY;
            year_ff  <= RST_TIME;
            cent_ff  <= RST_TIME;
        end
        else if (upd_go)
        begin
            sec_ff   <= nxt_sec;
            min_ff   <= nxt_min;
            hour_ff  <= nxt_hour;
            wday_ff  <= nxt_wday;
            mday_ff  <= nxt_mday;
            month_ff <= nxt_month;
            year_ff  <= nxt_year;
            cent_ff  <= nxt_cent;
        end
        else if (wr_acc && !i_addr[7])
        begin
            case (idx)
                ADDR_SEC:     sec_ff   <= i_wr_data;
                ADDR_MIN:     min_ff   <= i_wr_data;
                ADDR_HOUR:    hour_ff  <= i_wr_data;
                ADDR_WDAY:    wday_ff  <= i_wr_data;
                ADDR_MDAY:    mday_ff  <= i_wr_data;
                ADDR_MONTH:   month_ff <= i_wr_data;
                ADDR_YEAR:    year_ff  <= i_wr_data;
                ADDR_CENTURY: cent_ff  <= i_wr_data;
                default:      ;
            endcase
        end
    end

    // Alarm bytes; the day alarm stays writable during updates
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sec_alm_ff   <= RST_TIME;
            min_alm_ff   <= RST_TIME;
            hour_alm_ff  <= RST_TIME;
            mday_alm_ff  <= 6'h00;
            valid_ram_ff <= 1'b0;
        end
        else
        begin
            if (wr_acc && !i_addr[7])
            begin
                case (idx)
                    ADDR_SEC_ALM:  sec_alm_ff  <= i_wr_data;
                    ADDR_MIN_ALM:  min_alm_ff  <= i_wr_data;
                    ADDR_HOUR_ALM: hour_alm_ff <= i_wr_data;
                    ADDR_MDAY_ALM: mday_alm_ff <= i_wr_data[5:0];
                    default:       ;
                endcase
            end
            if (rd_acc && !i_addr[7] && (idx == ADDR_MDAY_ALM))
                valid_ram_ff <= 1'b1;
        end
    end

    // Control registers
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            div_rate_ff <= RST_DIV_RATE;
            mode_ff     <= RST_MODE;
            shared0_ff  <= 1'b0;
        end
        else if (wr_acc)
        begin
            if (!i_addr[7] && (idx == ADDR_DIV_RATE))
                div_rate_ff <= i_wr_data[6:0];
            if (!i_addr[7] && (idx == ADDR_MODE))
            begin
                mode_ff <= i_wr_data & MODE_WR_MASK;
                if (i_wr_data[MODE_HALT_BIT])
                    mode_ff[MODE_UIE_BIT] <= 1'b0;
            end
            if (idx == ADDR_SHARED)
                shared0_ff <= i_wr_data[0];
        end
    end

    // General purpose bytes of both banks
    always_ff @(posedge i_clk_sys)
    begin
        if (wr_acc && (idx > ADDR_MDAY_ALM) && (idx != ADDR_CENTURY) && (idx != ADDR_SHARED))
            gp_ram[i_addr] <= i_wr_data;
        else if (wr_acc && i_addr[7] && (idx <= ADDR_MDAY_ALM))
            gp_ram[i_addr] <= i_wr_data;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rd_data_ff <= 8'h00;
        else if (rd_acc)
        begin
            if (blocked && is_timed(i_addr))
                rd_data_ff <= UNDEF_DATA;
            else if (idx == ADDR_SHARED)
                rd_data_ff <= {i_shared_status, shared0_ff};
            else if (i_addr[7])
                rd_data_ff <= gp_ram[i_addr];
            else
            begin
                case (idx)
                    ADDR_SEC:       rd_data_ff <= sec_ff;
                    ADDR_SEC_ALM:   rd_data_ff <= sec_alm_ff;
                    ADDR_MIN:       rd_data_ff <= min_ff;
                    ADDR_MIN_ALM:   rd_data_ff <= min_alm_ff;
                    ADDR_HOUR:      rd_data_ff <= hour_ff;
                    ADDR_HOUR_ALM:  rd_data_ff <= hour_alm_ff;
                    ADDR_WDAY:      rd_data_ff <= wday_ff;
                    ADDR_MDAY:      rd_data_ff <= mday_ff;
                    ADDR_MONTH:     rd_data_ff <= month_ff;
                    ADDR_YEAR:      rd_data_ff <= year_ff;
                    ADDR_DIV_RATE:  rd_data_ff <= {(upd_state_ff != UPD_IDLE), div_rate_ff};
                    ADDR_MODE:      rd_data_ff <= mode_ff;
                    ADDR_IRQ_FLAGS: rd_data_ff <= i_irq_flags;
                    ADDR_MDAY_ALM:  rd_data_ff <= {valid_ram_ff, 1'b0, mday_alm_ff};
                    ADDR_CENTURY:   rd_data_ff <= cent_ff;
                    default:        rd_data_ff <= gp_ram[i_addr];
                endcase
            end
        end
    end

    // Alarm and update-end pulses
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            alarm_ff <= 1'b0;
            done_ff  <= 1'b0;
            pend_flag_ff <= 1'b0;
        end
        else
        begin
            alarm_ff <= upd_go && alm_hit(sec_alm_ff, nxt_sec) && alm_hit(min_alm_ff, nxt_min)
                        && alm_hit(hour_alm_ff, nxt_hour);
            done_ff  <= (upd_state_ff == UPD_BUSY) && i_tb_tick && (busy_cnt_ff == BUSY_LAST)
                        && !halt && !div_reset && !div_stop;
            pend_flag_ff <= !halt && !div_reset && !div_stop && ((upd_state_ff == UPD_PEND)
                            || ((upd_state_ff == UPD_IDLE) && i_tb_tick && (div_cnt_ff == DIV_PEND - 1'b1))
                            || ((upd_state_ff == UPD_BUSY) && !(i_tb_tick && (busy_cnt_ff == BUSY_LAST))));
        end
    end

    assign o_rd_data        = rd_data_ff;
    assign o_update_pending = pend_flag_ff;
    assign o_update_done    = done_ff;
    assign o_alarm_match    = alarm_ff;
    assign o_rate_select    = div_rate_ff[3:0];
    assign o_irq_enables    = mode_ff[MODE_PIE_BIT:MODE_UIE_BIT];
    assign o_shared_ctrl0   = shared0_ff;
endmodule

/* verification/rtca_checker.sv */
// Port-level assertions for the time, calendar and alarm core
`timescale 1ns/1ps
module rtca_checker
    import rtca_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_rst_b,
    input wire logic       i_tb_tick,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr_en,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_irq_flags,
    input wire logic [6:0] i_shared_status,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_update_pending,
    input wire logic       o_update_done,
    input wire logic       o_alarm_match,
    input wire logic [3:0] o_rate_select,
    input wire logic [2:0] o_irq_enables,
    input wire logic       o_shared_ctrl0
);
    logic [7:0] tick_cnt_ff;
    logic       pend_ff;
    logic       halt_ff;
    wire logic  mode_wr = i_wr_en && i_addr == {1'b0, ADDR_MODE};

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    // Time-base ticks seen while the pending flag is up
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tick_cnt_ff <= 8'h00;
            pend_ff     <= 1'b0;
            halt_ff     <= 1'b0;
        end
        else
        begin
            pend_ff <= o_update_pending;
            if (mode_wr)
                halt_ff <= i_wr_data[MODE_HALT_BIT];
            if (o_update_pending && !pend_ff)
                tick_cnt_ff <= {7'h00, i_tb_tick};
            else if (o_update_pending && i_tb_tick)
                tick_cnt_ff <= tick_cnt_ff + 8'h01;
        end
    end

    a_update_length: assert property (o_update_done |-> tick_cnt_ff == 8'(LEAD_TICKS + UPDATE_TICKS))
        else $error("update cycle length wrong");
    a_alarm_lead: assert property (o_alarm_match |-> tick_cnt_ff == 8'(LEAD_TICKS))
        else $error("alarm not one lead interval after pending");
    a_halt_blocks: assert property (halt_ff |=> !o_update_pending)
        else $error("pending while halted");
    a_mode_write: assert property (mode_wr |=> o_irq_enables == ($past(i_wr_data[7]) ?
        {$past(i_wr_data[6:5]), 1'b0} : $past(i_wr_data[6:4]))) else $error("enables wrong after mode write");
    a_rate_write: assert property (i_wr_en && i_addr == {1'b0, ADDR_DIV_RATE}
        |=> o_rate_select == $past(i_wr_data[3:0])) else $error("rate select not written");
    a_shared_write: assert property (i_wr_en && i_addr[6:0] == ADDR_SHARED
        |=> o_shared_ctrl0 == $past(i_wr_data[0])) else $error("shared bit 0 not written");
    a_shared_read: assert property (i_rd_en && i_addr[6:0] == ADDR_SHARED
        |=> o_rd_data[7:1] == $past(i_shared_status)) else $error("shared status bits wrong");
    a_flags_read: assert property (i_rd_en && i_addr == {1'b0, ADDR_IRQ_FLAGS}
        |=> o_rd_data == $past(i_irq_flags)) else $error("flag register read wrong");
    a_busy_undef: assert property (i_rd_en && !i_wr_en && i_addr == 8'h00 && pend_ff
        && o_update_pending && tick_cnt_ff >= 8'(LEAD_TICKS) |=> o_rd_data == UNDEF_DATA)
        else $error("time byte readable during update");
endmodule

bind rtca_core rtca_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tb_tick(i_tb_tick),
    .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .i_irq_flags(i_irq_flags),
    .i_shared_status(i_shared_status), .o_rd_data(o_rd_data), .o_update_pending(o_update_pending),
    .o_update_done(o_update_done), .o_alarm_match(o_alarm_match), .o_rate_select(o_rate_select),
    .o_irq_enables(o_irq_enables), .o_shared_ctrl0(o_shared_ctrl0));

/* verification/rtca_host_model.sv */
// Host processor model: byte accesses and the time-base tick
`timescale 1ns/1ps
module rtca_host_model
(
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rd_data,
    output logic      [7:0] o_addr,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_data,
    output logic            o_rd_en,
    output logic            o_tb_tick
);
    initial
    begin
        o_addr    = 8'h00;
        o_wr_en   = 1'b0;
        o_wr_data = 8'h00;
        o_rd_en   = 1'b0;
        o_tb_tick = 1'b0;
    end
    // Level high gives one tick every cycle
    task automatic tick_on(input logic on);
        @(posedge i_clk_sys);
        #1;
        o_tb_tick = on;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr    = a;
        o_wr_data = d;
        o_wr_en   = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr_en   = 1'b0;
        o_addr    = ~a;
        o_wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr  = a;
        o_rd_en = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_rd_en = 1'b0;
        o_addr  = ~a;
        d       = i_rd_data;
    endtask
    // Loads 0x00-0x09 and 0x32 with updates halted, then restores the mode
    task automatic load(input logic [7:0] mode, input logic [7:0] v [11]);
        wr(8'h0B, mode | 8'h80);
        for (int i = 0; i < 11; i++)
            wr((i < 10) ? 8'(i) : 8'h32, v[i]);
        wr(8'h0B, mode);
    endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the time, calendar and alarm core
`timescale 1ns/1ps
module tb;
    import rtca_pkg::*;
    logic       i_clk_sys       = 1'b0;
    logic       i_rst_b         = 1'b0;
    logic [7:0] i_irq_flags     = 8'h00;
    logic [6:0] i_shared_status = 7'h00;
    wire logic [7:0] addr, wr_data, rd_data;
    wire logic       wr_en, rd_en, tick, pend, done, alarm, shared0;
    wire logic [3:0] rate;
    wire logic [2:0] ien;
    int bad_count   = 0;
    int checks_done = 0;
    int alarm_cnt   = 0;
    int done_cnt    = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        if (alarm === 1'b1)
            alarm_cnt++;
        if (done === 1'b1)
            done_cnt++;
    end

    rtca_host_model u_host (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .o_addr(addr), .o_wr_en(wr_en),
        .o_wr_data(wr_data), .o_rd_en(rd_en), .o_tb_tick(tick));
    rtca_core uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tb_tick(tick), .i_addr(addr), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .i_irq_flags(i_irq_flags), .i_shared_status(i_shared_status),
        .o_rd_data(rd_data), .o_update_pending(pend), .o_update_done(done), .o_alarm_match(alarm),
        .o_rate_select(rate), .o_irq_enables(ien), .o_shared_ctrl0(shared0));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, v);
        check(v, e);
    endtask
    // Divider reset then release; waits for the pending flag
    task automatic step();
        int n;
        u_host.wr(8'h0A, 8'h10);
        u_host.wr(8'h0A, 8'h00);
        n = 0;
        while (pend !== 1'b1 && n < 20000)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        check({7'h00, n >= 16375 && n <= 16377}, 8'h01);
    endtask
    task automatic run_upd(input logic [7:0] mode, input logic [7:0] v [11], input logic [7:0] e [11],
                           input int alm);
        int m;
        alarm_cnt = 0;
        u_host.load(mode, v);
        step();
        repeat (10) @(posedge i_clk_sys);
        rchk(8'h00, UNDEF_DATA);
        rchk(8'h0D, 8'hBF);
        m = 0;
        while (done !== 1'b1 && m < 100)
        begin
            @(posedge i_clk_sys);
            #1;
            m++;
        end
        check({7'h00, m < 100}, 8'h01);
        check(8'(alarm_cnt), 8'(alm));
        for (int i = 0; i < 11; i++)
            rchk((i < 10) ? 8'(i) : 8'h32, e[i]);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        rchk(8'h00, RST_TIME);
        rchk(8'h06, RST_DAY);
        i_irq_flags = 8'hA5;
        u_host.wr(8'h0C, 8'h00);
        rchk(8'h0C, 8'hA5);
        u_host.wr(8'h0B, 8'hFF);
        rchk(8'h0B, 8'hE6);
        u_host.wr(8'h0A, 8'hFF);
        rchk(8'h0A, 8'h7F);
        u_host.wr(8'h0D, 8'hFF);
        u_host.rd(8'h0D, v);
        rchk(8'h0D, 8'hBF);
        i_shared_status = 7'h55;
        u_host.wr(8'hFF, 8'h01);
        rchk(8'h7F, 8'hAB);
        u_host.wr(8'h40, 8'h3C);
        u_host.wr(8'hC0, 8'hC3);
        rchk(8'h40, 8'h3C);
        rchk(8'hC0, 8'hC3);
        $display("Test regs finished");
    endtask
    task automatic t_year_end();
        run_upd(8'h00, '{8'h59, 8'h00, 8'h59, 8'h00, 8'h91, 8'h12, 8'h07, 8'h31, 8'h12, 8'h99, 8'h20},
                '{8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h12, 8'h01, 8'h01, 8'h01, 8'h00, 8'h21}, 1);
        $display("Test year end finished");
    endtask
    task automatic t_leap();
        run_upd(8'h06, '{8'h3B, 8'h00, 8'h3B, 8'h00, 8'h17, 8'hC0, 8'h03, 8'h1C, 8'h02, 8'h18, 8'h14},
                '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h04, 8'h1D, 8'h02, 8'h18, 8'h14}, 1);
        $display("Test leap finished");
    endtask
    task automatic t_month_end();
        run_upd(8'h06, '{8'h3B, 8'h05, 8'h3B, 8'h00, 8'h17, 8'h00, 8'h07, 8'h1C, 8'h02, 8'h19, 8'h14},
                '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h19, 8'h14}, 0);
        $display("Test month end finished");
    endtask
    task automatic t_halt();
        u_host.load(8'h02, '{8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h20});
        step();
        done_cnt = 0;
        u_host.wr(8'h0B, 8'h82);
        @(posedge i_clk_sys);
        #1;
        check({7'h00, pend}, 8'h00);
        repeat (100) @(posedge i_clk_sys);
        check(8'(done_cnt), 8'h00);
        rchk(8'h00, 8'h30);
        $display("Test halt finished");
    endtask

    initial
    begin
        repeat (3) @(posedge i_clk_sys);
        #1;
        i_rst_b = 1'b1;
        u_host.tick_on(1'b1);
        t_regs();
        t_year_end();
        t_leap();
        t_month_end();
        t_halt();
        print_verdict();
    end
    initial
    begin
        #(90_000 * 25);
        bad_count++;
        print_verdict();
    end
endmodule
